// *** hld_holdover_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - force bit puts the device in holdover
// - loop-1 lock loss enters holdover if enabled
// - tuning level past trip levels enters holdover with track on
// - loop-1 charge pump tristated during holdover
// - loop-1 lock flag low, detection keeps running
// - holdover status high throughout holdover
// - loop-2 lock flag kept if locked before
// - holdover level: manual value or last tracked
// - manual enable loads manual value at entry
// - holdover status routable to either status pin
// - host exits by disabling holdover mode
// - automatic exit once loop-1 lock count met
// - automatic exit needs phase error inside the window
// - loop-1 dividers to 16383, detector to 40MHz
// - loop-1 feedback from oscillator or zero-delay path
// - loop-2 dividers to 4095 and 262143
// - loop-2 prescaler divides 2 through 8
// - doubler ahead of loop-2 reference divider
// - in-window comparisons count up to target lock
// - one bad comparison drops lock at once
// - lock pin shows loop 1, loop 2 or both
// - tracked needs track on, manual off
// - tracked level updates every divided detector period
module hld_holdover_ctrl
  import hld_pkg::*;
#(
  parameter int LVL_W = 10,
  parameter int ERR_W = 16,
  parameter int CNT_W = 16,
  parameter int TRK_W = 16
)(
  input  wire logic                clk_sys_i,
  input  wire logic                rst_b_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wr_data_i,
  input  wire logic                wr_stb_i,
  input  wire logic                rd_stb_i,
  output logic [DATA_W-1:0]        rd_data_o,
  input  wire logic                pd1_tog_i,
  input  wire logic                pd2_tog_i,
  input  wire logic [ERR_W-1:0]    err1_i,
  input  wire logic [ERR_W-1:0]    err2_i,
  input  wire logic [LVL_W-1:0]    vtune_i,
  output logic                     holdover_o,
  output logic                     cp1_hiz_o,
  output logic [LVL_W-1:0]         tune_level_o,
  output logic                     lock1_o,
  output logic                     lock2_o,
  output logic                     lock_status_pin_o,
  output logic                     holdover_status_pin_o,
  output logic [L1_DIV_W-1:0]      l1_ref_div_o,
  output logic [L1_DIV_W-1:0]      l1_fb_div_o,
  output logic [L2_REF_W-1:0]      l2_ref_div_o,
  output logic [L2_FB_W-1:0]       l2_fb_div_o,
  output logic [PRE_W-1:0]         l2_presc_o,
  output logic                     ref_doubler_o,
  output logic                     osc_out_sel_o,
  output logic [1:0]               fb_src_o
);
  // control fields
  logic                 force_hold;
  logic [1:0]           hold_mode;
  logic                 lock_loss_trigger_off;
  logic                 rail_trigger_enable;
  logic                 track_enable;
  logic                 manual_level_enable;
  logic                 reference_doubler_enable;
  logic                 oscillator_output_select;
  logic                 zero_delay;
  logic                 fb_external;
  logic [LVL_W-1:0]     manual_level_value;
  logic [LVL_W-1:0]     upper_trip_level;
  logic [LVL_W-1:0]     lower_trip_level;
  logic [ERR_W-1:0]     phase_window_size1;
  logic [ERR_W-1:0]     phase_window_size2;
  logic [CNT_W-1:0]     lock_count_target1;
  logic [CNT_W-1:0]     lock_count_target2;
  logic [2:0]           lock_pin_source_select;
  logic [2:0]           hold_pin_source_select;
  logic [TRK_W-1:0]     track_div;
  // synchronisers and detector inputs
  logic [2:0]           pd1_sync;
  logic [2:0]           pd2_sync;
  logic [ERR_W-1:0]     err1_s1, err1_s2, err2_s1, err2_s2;
  logic [LVL_W-1:0]     vt_s1, vt_s2;
  logic                 cmp1, cmp2;
  logic                 lock1_raw, lock2_raw, lock1_raw_q;
  // holdover machine and tracking
  hld_ho_state_t        state, next_state;
  logic                 rail, lock_loss_trig, rail_trig, auto_exit, entering, next_hold;
  logic [TRK_W-1:0]     trk_cnt;
  logic [LVL_W-1:0]     tracked;
  logic [DATA_W-1:0]    next_rd_data;
  logic [PRE_W-1:0]     pre_wr;

  // pin crossing: two flops, then a third for the toggle edge
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      pd1_sync <= '0;
      pd2_sync <= '0;
      err1_s1  <= '0;
      err1_s2  <= '0;
      err2_s1  <= '0;
      err2_s2  <= '0;
      vt_s1    <= '0;
      vt_s2    <= '0;
    end
    else
    begin
      pd1_sync <= {pd1_sync[1:0], pd1_tog_i};
      pd2_sync <= {pd2_sync[1:0], pd2_tog_i};
      err1_s1  <= err1_i;
      err1_s2  <= err1_s1;
      err2_s1  <= err2_i;
      err2_s2  <= err2_s1;
      vt_s1    <= vtune_i;
      vt_s2    <= vt_s1;
    end
  end

  // one pulse per phase comparison
  assign cmp1 = pd1_sync[2] ^ pd1_sync[1];
  assign cmp2 = pd2_sync[2] ^ pd2_sync[1];

  // loop-1 detector keeps running in holdover
  hld_lock_det #(.CNT_W(CNT_W), .ERR_W(ERR_W)) u_lock1 (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .cmp_i     (cmp1),
    .err_i     (err1_s2),
    .window_i  (phase_window_size1),
    .target_i  (lock_count_target1),
    .lock_o    (lock1_raw),
    .cnt_o     ()
  );

  // loop-2 detector
  hld_lock_det #(.CNT_W(CNT_W), .ERR_W(ERR_W)) u_lock2 (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .cmp_i     (cmp2),
    .err_i     (err2_s2),
    .window_i  (phase_window_size2),
    .target_i  (lock_count_target2),
    .lock_o    (lock2_raw),
    .cnt_o     ()
  );

  // prescaler write clamped into 2..8
  assign pre_wr = (wr_data_i[PRE_W-1:0] < PRE_MIN) ? PRE_MIN :
                  (wr_data_i[PRE_W-1:0] > PRE_MAX) ? PRE_MAX : wr_data_i[PRE_W-1:0];

  // register writes
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      force_hold               <= 1'b0;
      hold_mode                <= MODE_DISABLED;
      lock_loss_trigger_off    <= 1'b0;
      rail_trigger_enable      <= 1'b0;
      track_enable             <= 1'b0;
      manual_level_enable      <= 1'b0;
      reference_doubler_enable <= 1'b0;
      oscillator_output_select <= 1'b0;
      zero_delay               <= 1'b0;
      fb_external              <= 1'b0;
      manual_level_value       <= '0;
      upper_trip_level         <= '1;
      lower_trip_level         <= '0;
      phase_window_size1       <= '0;
      phase_window_size2       <= '0;
      lock_count_target1       <= '1;
      lock_count_target2       <= '1;
      lock_pin_source_select   <= SRC_LOW;
      hold_pin_source_select   <= SRC_LOW;
      track_div                <= '1;
      l1_ref_div_o             <= '1;
      l1_fb_div_o              <= '1;
      l2_ref_div_o             <= '1;
      l2_fb_div_o              <= '1;
      l2_presc_o               <= PRE_MIN;
    end
    else if (wr_stb_i)
    begin
      unique case (addr_i)
        OFS_CTRL:
        begin
          force_hold               <= wr_data_i[CTRL_FORCE];
          hold_mode                <= wr_data_i[CTRL_MODE +: 2];
          lock_loss_trigger_off    <= wr_data_i[CTRL_LLOFF];
          rail_trigger_enable      <= wr_data_i[CTRL_RAIL];
          track_enable             <= wr_data_i[CTRL_TRACK];
          manual_level_enable      <= wr_data_i[CTRL_MAN];
          reference_doubler_enable <= wr_data_i[CTRL_DBL];
          oscillator_output_select <= wr_data_i[CTRL_OSEL];
          zero_delay               <= wr_data_i[CTRL_ZDLY];
          fb_external              <= wr_data_i[CTRL_FBEXT];
        end
        OFS_LEVEL: manual_level_value <= wr_data_i[LVL_W-1:0];
        OFS_TRIP:
        begin
          lower_trip_level <= wr_data_i[LVL_W-1:0];
          upper_trip_level <= wr_data_i[HI_FIELD +: LVL_W];
        end
        OFS_LOCK1:
        begin
          phase_window_size1 <= wr_data_i[ERR_W-1:0];
          lock_count_target1 <= wr_data_i[HI_FIELD +: CNT_W];
        end
        OFS_LOCK2:
        begin
          phase_window_size2 <= wr_data_i[ERR_W-1:0];
          lock_count_target2 <= wr_data_i[HI_FIELD +: CNT_W];
        end
        OFS_PINS:
        begin
          lock_pin_source_select <= wr_data_i[2:0];
          hold_pin_source_select <= wr_data_i[PINS_HOLD +: 3];
        end
        OFS_TRACK: track_div    <= wr_data_i[TRK_W-1:0];
        OFS_L1REF: l1_ref_div_o <= wr_data_i[L1_DIV_W-1:0];
        OFS_L1FB:  l1_fb_div_o  <= wr_data_i[L1_DIV_W-1:0];
        OFS_L2REF: l2_ref_div_o <= wr_data_i[L2_REF_W-1:0];
        OFS_L2FB:  l2_fb_div_o  <= wr_data_i[L2_FB_W-1:0];
        OFS_PRESC: l2_presc_o   <= pre_wr;
        default: ;
      endcase
    end
  end

  // loop-2 reference path and loop-1 feedback routing
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ref_doubler_o <= 1'b0;
      osc_out_sel_o <= 1'b0;
      fb_src_o      <= FB_OSC;
    end
    else
    begin
      ref_doubler_o <= reference_doubler_enable;
      osc_out_sel_o <= oscillator_output_select;
      fb_src_o      <= !zero_delay ? FB_OSC : (fb_external ? FB_EXT : FB_INT);
    end
  end

  // holdover entry and exit conditions
  assign rail           = (vt_s2 > upper_trip_level) || (vt_s2 < lower_trip_level);
  assign lock_loss_trig = lock1_raw_q && !lock1_raw && hold_mode == MODE_ENABLED
                          && !lock_loss_trigger_off;
  assign rail_trig      = rail && hold_mode == MODE_ENABLED && rail_trigger_enable
                          && track_enable;
  assign auto_exit      = lock1_raw && !lock1_raw_q;

  // holdover next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      HO_RUN:
        if (force_hold || lock_loss_trig || rail_trig)
          next_state = HO_HOLD;
      HO_HOLD:
        if (!force_hold && (hold_mode == MODE_DISABLED || auto_exit))
          next_state = HO_RUN;
    endcase
  end

  assign next_hold = next_state == HO_HOLD;
  assign entering  = state == HO_RUN && next_hold;

  // holdover state and status flops
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      state       <= HO_RUN;
      lock1_raw_q <= 1'b0;
      holdover_o  <= 1'b0;
      cp1_hiz_o   <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      lock1_raw_q <= lock1_raw;
      holdover_o  <= next_hold;
      cp1_hiz_o   <= next_hold;
    end
  end

  // tracked level sampled once per divided detector period
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      trk_cnt <= '0;
      tracked <= '0;
    end
    else if (track_enable && cmp1)
    begin
      if (trk_cnt >= track_div - 1'b1)
      begin
        trk_cnt <= '0;
        if (state == HO_RUN)
          tracked <= vt_s2;
      end
      else
        trk_cnt <= trk_cnt + 1'b1;
    end
  end

  // tuning level: follows tracking, frozen at entry
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      tune_level_o <= '0;
    else if (entering)
      tune_level_o <= manual_level_enable ? manual_level_value : tracked;
    else if (state == HO_RUN)
      tune_level_o <= tracked;
  end

  // lock flags, loop 1 masked and loop 2 frozen in holdover
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      lock1_o <= 1'b0;
      lock2_o <= 1'b0;
    end
    else
    begin
      lock1_o <= lock1_raw && !next_hold;
      lock2_o <= (next_hold && holdover_o) ? lock2_o : lock2_raw;
    end
  end

  // status pin source select
  function automatic logic pin_mux(input logic [2:0] sel, input logic l1,
                                   input logic l2, input logic ho);
    unique case (sel)
      SRC_LOCK1: pin_mux = l1;
      SRC_LOCK2: pin_mux = l2;
      SRC_BOTH:  pin_mux = l1 && l2;
      SRC_HOLD:  pin_mux = ho;
      default:   pin_mux = 1'b0;
    endcase
  endfunction

  // status pins
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      lock_status_pin_o     <= 1'b0;
      holdover_status_pin_o <= 1'b0;
    end
    else
    begin
      lock_status_pin_o     <= pin_mux(lock_pin_source_select, lock1_o, lock2_o,
                                       holdover_o);
      holdover_status_pin_o <= pin_mux(hold_pin_source_select, lock1_o, lock2_o,
                                       holdover_o);
    end
  end

  // read data mux, zero for unmapped addresses
  always_comb
  begin
    next_rd_data = '0;
    unique case (addr_i)
      OFS_CTRL:
      begin
        next_rd_data[CTRL_FORCE]    = force_hold;
        next_rd_data[CTRL_MODE +: 2] = hold_mode;
        next_rd_data[CTRL_LLOFF]    = lock_loss_trigger_off;
        next_rd_data[CTRL_RAIL]     = rail_trigger_enable;
        next_rd_data[CTRL_TRACK]    = track_enable;
        next_rd_data[CTRL_MAN]      = manual_level_enable;
        next_rd_data[CTRL_DBL]      = reference_doubler_enable;
        next_rd_data[CTRL_OSEL]     = oscillator_output_select;
        next_rd_data[CTRL_ZDLY]     = zero_delay;
        next_rd_data[CTRL_FBEXT]    = fb_external;
      end
      OFS_LEVEL: next_rd_data[LVL_W-1:0] = manual_level_value;
      OFS_TRIP:
      begin
        next_rd_data[LVL_W-1:0]         = lower_trip_level;
        next_rd_data[HI_FIELD +: LVL_W] = upper_trip_level;
      end
      OFS_LOCK1:
      begin
        next_rd_data[ERR_W-1:0]         = phase_window_size1;
        next_rd_data[HI_FIELD +: CNT_W] = lock_count_target1;
      end
      OFS_LOCK2:
      begin
        next_rd_data[ERR_W-1:0]         = phase_window_size2;
        next_rd_data[HI_FIELD +: CNT_W] = lock_count_target2;
      end
      OFS_PINS:
      begin
        next_rd_data[2:0]             = lock_pin_source_select;
        next_rd_data[PINS_HOLD +: 3]  = hold_pin_source_select;
      end
      OFS_TRACK: next_rd_data[TRK_W-1:0]    = track_div;
      OFS_L1REF: next_rd_data[L1_DIV_W-1:0] = l1_ref_div_o;
      OFS_L1FB:  next_rd_data[L1_DIV_W-1:0] = l1_fb_div_o;
      OFS_L2REF: next_rd_data[L2_REF_W-1:0] = l2_ref_div_o;
      OFS_L2FB:  next_rd_data[L2_FB_W-1:0]  = l2_fb_div_o;
      OFS_PRESC: next_rd_data[PRE_W-1:0]    = l2_presc_o;
      OFS_STATUS:
      begin
        next_rd_data[5:0] = {rail, lock2_raw, lock1_raw, lock2_o, lock1_o, holdover_o};
        next_rd_data[HI_FIELD +: LVL_W] = tracked;
      end
      default: ;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      rd_data_o <= '0;
    else
      rd_data_o <= rd_stb_i ? next_rd_data : '0;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_force_enters_hold: assert property (force_hold |=> holdover_o && cp1_hiz_o)
    else $error("force bit did not enter holdover");
  chk_lockloss_enters: assert property (state == HO_RUN && lock_loss_trig |=> holdover_o)
    else $error("loss of loop-1 lock did not enter holdover");
  chk_lock1_masked: assert property (holdover_o |-> !lock1_o && cp1_hiz_o)
    else $error("loop-1 lock flag high in holdover");
  chk_lock2_frozen: assert property (holdover_o && $past(holdover_o) |-> $stable(lock2_o))
    else $error("loop-2 lock flag moved during holdover");
  chk_manual_level: assert property ($rose(holdover_o) && $past(manual_level_enable)
                                     |-> tune_level_o == $past(manual_level_value))
    else $error("manual level not loaded at holdover entry");
  chk_level_frozen: assert property (holdover_o ##1 holdover_o |-> $stable(tune_level_o))
    else $error("tuning level moved during holdover");
  chk_manual_exit: assert property (holdover_o && !force_hold && hold_mode == MODE_DISABLED
                                    |=> !holdover_o)
    else $error("disabling holdover mode did not exit");
  chk_hold_pin: assert property (hold_pin_source_select == SRC_HOLD && !wr_stb_i
                                 |=> holdover_status_pin_o == $past(holdover_o))
    else $error("holdover pin does not follow holdover status");
  chk_auto_exit: assert property (state == HO_HOLD && !force_hold && auto_exit
                                  ##1 1'b1 |-> !holdover_o)
    else $error("holdover not left on loop-1 relock");
  cov_force_entry: cover property (force_hold ##1 holdover_o);
  cov_rail_entry: cover property (state == HO_RUN && rail_trig && !force_hold ##1 holdover_o);
  cov_auto_exit: cover property (holdover_o ##1 !holdover_o && hold_mode == MODE_ENABLED);
endmodule

// *** hld_holdover_ctrl_bench.sv ***
`timescale 1ns/1ps
module hld_holdover_ctrl_bench
  import hld_pkg::*;
;
  logic        clk_sys_i = 0, rst_b_i = 0, wr_stb_i = 0, rd_stb_i = 0, src_en = 0;
  logic [7:0]  addr_i = 8'h0;
  logic [31:0] wr_data_i = 32'h0, rd_data_o, seed = 32'h00010962;
  logic [15:0] err_val = 16'h0, err1_i, err2_val = 16'h1, err2_i;
  logic [9:0]  vtune_i = 10'h200, tune_level_o;
  logic        pd1_tog_i, pd2_tog_i, holdover_o, cp1_hiz_o, lock1_o, lock2_o;
  logic        lock_status_pin_o, holdover_status_pin_o, ref_doubler_o, osc_out_sel_o;
  logic [13:0] l1_ref_div_o, l1_fb_div_o;
  logic [11:0] l2_ref_div_o;
  logic [17:0] l2_fb_div_o;
  logic [3:0]  l2_presc_o;
  logic [1:0]  fb_src_o;
  int          fails = 0, samples_checked = 0;
  // clock and design under test
  always #20 clk_sys_i = ~clk_sys_i;
  hld_holdover_ctrl u_dut (.clk_sys_i, .rst_b_i, .addr_i, .wr_data_i, .wr_stb_i, .rd_stb_i,
    .rd_data_o, .pd1_tog_i, .pd2_tog_i, .err1_i, .err2_i, .vtune_i,
    .holdover_o, .cp1_hiz_o, .tune_level_o, .lock1_o, .lock2_o, .lock_status_pin_o,
    .holdover_status_pin_o, .l1_ref_div_o, .l1_fb_div_o, .l2_ref_div_o, .l2_fb_div_o,
    .l2_presc_o, .ref_doubler_o, .osc_out_sel_o, .fb_src_o);
  hld_ref_src u_src (.clk_sys_i, .rst_b_i, .en_i(src_en), .err_val_i(err_val),
    .tog_o(pd1_tog_i), .err_o(err1_i));
  hld_ref_src u_src2 (.clk_sys_i, .rst_b_i, .en_i(src_en), .err_val_i(err2_val),
    .tog_o(pd2_tog_i), .err_o(err2_i));
  // xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // prescaler value kept after clamping
  function automatic logic [31:0] exp_presc(input int v);
    return (v < 2) ? 32'h2 : ((v > 8) ? 32'h8 : 32'(v));
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_stb_i <= 1'b0;
    #1 chk("rd_data", exp, rd_data_o);
    @(posedge clk_sys_i);
    #1 chk("rd_idle", 32'h0, rd_data_o);
  endtask
  // bounded wait for lock (sel 0) or holdover (sel 1) to reach v
  task automatic wt(input int sel, input logic v);
    for (int i = 0; i < 400 && (sel ? holdover_o : lock1_o) !== v; i++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    chk(sel ? "holdover_wait" : "lock1_wait", {31'h0, v}, {31'h0, sel ? holdover_o : lock1_o});
    if ((sel ? holdover_o : lock1_o) !== v)
      tally_and_finish();
  endtask
  // main sequence
  initial
  begin
    logic [31:0] d, lvl, e;
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(OFS_TRIP, 32'h03ff0000);
    rd(8'h3c, 32'h0);
    for (int v = 0; v < 16; v++)
    begin
      wr(OFS_PRESC, 32'(v));
      #1 chk("presc", exp_presc(v), {28'h0, l2_presc_o});
    end
    wr(OFS_L1REF, 32'h3fff);
    rd(OFS_L1REF, 32'h3fff);
    wr(OFS_L1FB, 32'h3fff);
    #1 chk("l1_fb", 32'h3fff, {18'h0, l1_fb_div_o});
    d = rnd();
    wr(OFS_L2REF, d);
    rd(OFS_L2REF, d & 32'hfff);
    wr(OFS_L2FB, 32'h3ffff);
    rd(OFS_L2FB, 32'h3ffff);
    // lock, then loss of lock triggers holdover
    lvl = rnd() & 32'h3ff;
    wr(OFS_LEVEL, lvl);
    wr(OFS_PINS, 32'h41);
    wr(OFS_LOCK1, 32'h0003000a);
    wr(OFS_LOCK2, 32'h0002000a);
    wr(OFS_CTRL, 32'hc4);
    @(posedge clk_sys_i);
    err_val <= 16'(rnd() % 10);
    src_en <= 1'b1;
    #1 chk("doubler", 32'h1, {31'h0, ref_doubler_o});
    wt(0, 1'b1);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("lock_pin", 32'h1, {31'h0, lock_status_pin_o});
    @(posedge clk_sys_i);
    err_val <= 16'(10 + rnd() % 100);
    wt(1, 1'b1);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("hiz", 32'h1, {31'h0, cp1_hiz_o});
    chk("lock1_held", 32'h0, {31'h0, lock1_o});
    chk("level", lvl, {22'h0, tune_level_o});
    chk("ho_pin", 32'h1, {31'h0, holdover_status_pin_o});
    // loop 2 loses its window in holdover: flag stays, raw lock drops
    @(posedge clk_sys_i);
    err2_val <= 16'h20;
    repeat (24) @(posedge clk_sys_i);
    #1 chk("lock2_held", 32'h1, {31'h0, lock2_o});
    rd(OFS_STATUS, 32'h5);
    @(posedge clk_sys_i);
    err_val <= 16'(rnd() % 10);
    wt(1, 1'b0);
    // forced entry and host exit
    wr(OFS_CTRL, 32'h1);
    @(posedge clk_sys_i);
    #1 chk("forced", 32'h1, {31'h0, holdover_o});
    wr(OFS_CTRL, 32'h0);
    @(posedge clk_sys_i);
    #1 chk("host_exit", 32'h0, {31'h0, holdover_o});
    // feedback routing, first pass forced onto the external path
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 32'h600 : (rnd() & 32'h700);
      e = {30'h0, d[9] ? (d[10] ? FB_EXT : FB_INT) : FB_OSC};
      wr(OFS_CTRL, d);
      @(posedge clk_sys_i);
      #1 chk("fb_src", e, {30'h0, fb_src_o});
      chk("osc_sel", {31'h0, d[8]}, {31'h0, osc_out_sel_o});
    end
    // tracked holdover entered by the tuning level leaving the trip band
    wr(OFS_TRACK, 32'h1);
    wr(OFS_TRIP, 32'h03000100);
    e = 32'h100 + rnd() % 32'h200;
    vtune_i <= e[9:0];
    wr(OFS_CTRL, 32'h34);
    repeat (30) @(posedge clk_sys_i);
    vtune_i <= 10'h3f0;
    wt(1, 1'b1);
    chk("tracked", e, {22'h0, tune_level_o});
    tally_and_finish();
  end
endmodule

// *** hld_lock_det.sv ***
`timescale 1ns/1ps
package hld_pkg;
  // register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LEVEL  = 8'h04;
  localparam logic [7:0] OFS_TRIP   = 8'h08;
  localparam logic [7:0] OFS_LOCK1  = 8'h0c;
  localparam logic [7:0] OFS_LOCK2  = 8'h10;
  localparam logic [7:0] OFS_PINS   = 8'h14;
  localparam logic [7:0] OFS_TRACK  = 8'h18;
  localparam logic [7:0] OFS_L1REF  = 8'h1c;
  localparam logic [7:0] OFS_L1FB   = 8'h20;
  localparam logic [7:0] OFS_L2REF  = 8'h24;
  localparam logic [7:0] OFS_L2FB   = 8'h28;
  localparam logic [7:0] OFS_PRESC  = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // control register fields
  localparam int CTRL_FORCE = 0;
  localparam int CTRL_MODE  = 1;
  localparam int CTRL_LLOFF = 3;
  localparam int CTRL_RAIL  = 4;
  localparam int CTRL_TRACK = 5;
  localparam int CTRL_MAN   = 6;
  localparam int CTRL_DBL   = 7;
  localparam int CTRL_OSEL  = 8;
  localparam int CTRL_ZDLY  = 9;
  localparam int CTRL_FBEXT = 10;
  localparam int HI_FIELD   = 16;
  localparam int PINS_HOLD  = 4;
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_ENABLED  = 2'h2;
  // divider limits
  localparam int L1_DIV_W = 14;
  localparam int L2_REF_W = 12;
  localparam int L2_FB_W  = 18;
  localparam int PRE_W    = 4;
  localparam logic [3:0] PRE_MIN = 4'h2;
  localparam logic [3:0] PRE_MAX = 4'h8;
  // feedback source codes
  localparam logic [1:0] FB_OSC = 2'h0;
  localparam logic [1:0] FB_INT = 2'h1;
  localparam logic [1:0] FB_EXT = 2'h2;
  // phase detector rate ceiling against the system clock
  localparam int PD1_MAX_MHZ  = 40;
  localparam int CLK_MHZ      = 25;
  localparam int PD1_MIN_CYC  = (CLK_MHZ + PD1_MAX_MHZ - 1) / PD1_MAX_MHZ;
  typedef enum logic [2:0] {SRC_LOW, SRC_LOCK1, SRC_LOCK2, SRC_BOTH, SRC_HOLD} hld_pin_src_t;
  typedef enum logic {HO_RUN, HO_HOLD} hld_ho_state_t;
endpackage

// digital lock detector for one loop
module hld_lock_det
  import hld_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int ERR_W = 16
)(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic             cmp_i,
  input  wire logic [ERR_W-1:0] err_i,
  input  wire logic [ERR_W-1:0] window_i,
  input  wire logic [CNT_W-1:0] target_i,
  output logic                  lock_o,
  output logic [CNT_W-1:0]      cnt_o
);
  logic in_win;
  logic [CNT_W-1:0] next_cnt;

  // comparison inside the window, saturating count
  assign in_win   = err_i < window_i;
  assign next_cnt = (&cnt_o) ? cnt_o : cnt_o + 1'b1;

  // count good comparisons, assert at target, drop on a bad one
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      cnt_o  <= '0;
      lock_o <= 1'b0;
    end
    else if (cmp_i)
    begin
      if (in_win)
      begin
        cnt_o <= next_cnt;
        if (next_cnt >= target_i)
          lock_o <= 1'b1;
      end
      else
      begin
        cnt_o  <= '0;
        lock_o <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_lock_drop_bad: assert property (cmp_i && !in_win |=> !lock_o && cnt_o == '0)
    else $error("lock or count survived an out-of-window comparison");
  chk_lock_rise_cause: assert property ($rose(lock_o) |-> $past(cmp_i) && $past(in_win)
                                        && cnt_o >= $past(target_i))
    else $error("lock rose without reaching target");
  chk_count_hold_idle: assert property (!cmp_i |=> $stable(cnt_o) && $stable(lock_o))
    else $error("lock state moved without a comparison");
  cov_lock_reached: cover property ($rose(lock_o));
endmodule

// *** hld_ref_src.sv ***
`timescale 1ns/1ps
// reference source for either loop: one comparison marker toggle every 8 cycles
module hld_ref_src (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        en_i,
  input  wire logic [15:0] err_val_i,
  output logic             tog_o,
  output logic [15:0]      err_o
);
  logic [2:0] phase;
  // error settles four cycles before and after each toggle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      phase <= 3'h0;
      tog_o <= 1'b0;
      err_o <= 16'h0;
    end
    else
    begin
      phase <= phase + 3'h1;
      if (phase == 3'h0)
        err_o <= err_val_i;
      if (phase == 3'h4 && en_i)
        tog_o <= ~tog_o; // marker stands still while disabled
    end
  end
endmodule
